// *** pin_board_model.sv ***
// board-side model of the simple port pins and interrupt lines
module pin_board_model (
    input  wire port9_pkg::spd_drive_t spd_pins,
    input  wire logic [3:0]            board_level,
    input  wire logic [2:0]            irq_level,
    output logic [3:0]                 spd_in,
    output logic [2:0]                 ext_irq_in
);
    timeunit 1ns;
    timeprecision 1ns;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            spd_in[i] = spd_pins.oe[i] ? spd_pins.out[i] : board_level[i];
    end

    assign ext_irq_in = irq_level;
endmodule

// *** port9_defs.svh ***
// register indices, field masks and reset values of the port block
`ifndef PORT9_DEFS_SVH
`define PORT9_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_PU_WORD   32'h0FFFFC52
`define IDX_PU_HIGH   32'h0FFFFC53
`define IDX_SPD_DATA  32'hFFFFF00E
`define IDX_SPD_DIR   32'hFFFFF02E
`define IDX_FALL_SEL  32'hFFFFFC13
`define IDX_RISE_SEL  32'hFFFFFC33
`define IDX_FUNC_CTL  32'hFFFFF472

`define PU_RST        16'h0000
`define PU_FULL_MASK  16'hFFFF
`define PU_SMALL_MASK 16'hE3C3
`define SEL_RST       3'h0
`define SEL_LSB       5
`define FUNC_RST      3'h0
`define FUNC_LSB      13
`define SPD_DATA_RST  4'h0
`define SPD_OE_RST    4'h0

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** port9_pkg.sv ***
// types shared by the port block and its bench
package port9_pkg;

    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } edge_mode_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } spd_drive_t;

    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } addr_drive_t;

endpackage

// *** port9_regs.sv ***
// pull-up, edge select and simple i/o port logic behind an axi4-lite slave
//
// Summary of operation
// - each pull-up bit connects its pin pull-up when set; resets to zero
// - pull-up word is one 16-bit register; low and high bytes byte-accessible
// - upper pull-up bits reach through the high-byte register, bits 0 to 7
// - small variants implement pull-up bits 0,1,6-9,13-15 only; rest zero
// - falling/rising pair picks edge: none, rising, falling or both
// - falling select register: 8 bits, resets 00H, bits 5-7 only
// - rising select register: 8 bits, resets 00H, bits 5-7 only
// - select bits 5, 6, 7 steer interrupt inputs four, five, six
// - pins 13-15 are interrupt inputs if function bit set, else address out
// - simple port has four pins on largest variant only, no pull-up
// - simple port data: 8 bits, bits 0-3 data, bits 4-7 read zero
// - input mode: read gives live pin, write only loads the latch
// - output mode: read gives latch, write drives pin at once
// - direction register selects input or output per simple port pin
`include "port9_defs.svh"

module port9_regs #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [15:0]                pullup_en,
    input  wire logic [2:0]            ext_irq_in,
    output logic [2:0]                 ext_irq_event,
    input  wire logic [2:0]            addr_hi_src,
    output port9_pkg::addr_drive_t     addr_hi_pins,
    input  wire logic [3:0]            spd_in,
    output port9_pkg::spd_drive_t      spd_pins
);

    localparam logic [15:0] PU_IMPL =
        LARGE_VARIANT ? `PU_FULL_MASK : `PU_SMALL_MASK;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
        hit = (a[31:2] == idx[29:0]);
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = hit(a, `IDX_PU_WORD) || hit(a, `IDX_PU_HIGH)
              || hit(a, `IDX_FALL_SEL) || hit(a, `IDX_RISE_SEL)
              || hit(a, `IDX_FUNC_CTL) || hit(a, `IDX_SPD_DATA)
              || hit(a, `IDX_SPD_DIR);
    endfunction

    logic [1:0]  rst_pipe_r;
    logic        rst_sync_n;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic        wr_go;
    logic [15:0] pu_r;
    logic [2:0]  fall_r;
    logic [2:0]  rise_r;
    logic [2:0]  func_r;
    logic [3:0]  spd_lat_r;
    logic [3:0]  spd_oe_r;
    logic [3:0]  spd_rd;
    logic [31:0] rd_nxt;
    logic [2:0]  irq_prev_r;
    logic [2:0]  event_nxt;
    logic [2:0]  event_r;
    logic [2:0]  a_out_r;
    logic [2:0]  a_oe_r;

    // reset is released through two flops so every flop on rst_sync_n leaves reset together
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rst_pipe_r <= 2'h0;
        else
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
    assign rst_sync_n = rst_pipe_r[1];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_sync_n);

    // write channels are held independently; the write lands once both exist
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 32'h0;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
            end
        end
    end
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pu_r <= `PU_RST;
        else if (wr_go && hit(aw_addr_r, `IDX_PU_WORD))
        begin
            if (w_strb_r[0])
                pu_r[7:0] <= w_data_r[7:0] & PU_IMPL[7:0];
            if (w_strb_r[1])
                pu_r[15:8] <= w_data_r[15:8] & PU_IMPL[15:8];
        end
        else if (wr_go && hit(aw_addr_r, `IDX_PU_HIGH) && w_strb_r[0])
            pu_r[15:8] <= w_data_r[7:0] & PU_IMPL[15:8];
    end
    assign pullup_en = pu_r;

    // only bits 5 to 7 are stored
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fall_r <= `SEL_RST;
            rise_r <= `SEL_RST;
        end
        else if (wr_go && w_strb_r[0])
        begin
            if (hit(aw_addr_r, `IDX_FALL_SEL))
                fall_r <= w_data_r[`SEL_LSB +: 3];
            if (hit(aw_addr_r, `IDX_RISE_SEL))
                rise_r <= w_data_r[`SEL_LSB +: 3];
        end
    end

    // function bits 13 to 15 of the function control word
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            func_r <= `FUNC_RST;
        else if (wr_go && hit(aw_addr_r, `IDX_FUNC_CTL) && w_strb_r[1])
            func_r <= w_data_r[`FUNC_LSB +: 3];
    end

    // simple port exists only on the large variant
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            spd_lat_r <= `SPD_DATA_RST;
            spd_oe_r  <= `SPD_OE_RST;
        end
        else if (LARGE_VARIANT && wr_go && w_strb_r[0])
        begin
            if (hit(aw_addr_r, `IDX_SPD_DATA))
                spd_lat_r <= w_data_r[3:0];
            if (hit(aw_addr_r, `IDX_SPD_DIR))
                spd_oe_r <= ~w_data_r[3:0];
        end
    end
    // latch and enable drive the pins directly, so a write shows at once
    assign spd_pins = '{out: spd_lat_r, oe: spd_oe_r};

    // input bits read the pin, output bits read the latch
    assign spd_rd = LARGE_VARIANT
        ? ((spd_in & ~spd_oe_r) | (spd_lat_r & spd_oe_r)) : 4'h0;

    // data bits 4 to 7 read zero
    always_comb
    begin
        rd_nxt = 32'h0;
        if (hit(s_axi_araddr, `IDX_PU_WORD))
            rd_nxt = {16'h0, pu_r};
        else if (hit(s_axi_araddr, `IDX_PU_HIGH))
            rd_nxt = {24'h0, pu_r[15:8]};
        else if (hit(s_axi_araddr, `IDX_FALL_SEL))
            rd_nxt = {24'h0, fall_r, 5'h0};
        else if (hit(s_axi_araddr, `IDX_RISE_SEL))
            rd_nxt = {24'h0, rise_r, 5'h0};
        else if (hit(s_axi_araddr, `IDX_FUNC_CTL))
            rd_nxt = {16'h0, func_r, 13'h0};
        else if (hit(s_axi_araddr, `IDX_SPD_DATA))
            rd_nxt = {28'h0, spd_rd};
        else if (hit(s_axi_araddr, `IDX_SPD_DIR))
            rd_nxt = {28'h0, LARGE_VARIANT ? ~spd_oe_r : 4'h0};
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_nxt;
            s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    // pins are taken as synchronous, one flop of history is enough
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_prev_r <= 3'h0;
        else
            irq_prev_r <= ext_irq_in;
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_edge
            port9_pkg::edge_mode_t mode;
            logic                  rose;
            logic                  fell;
            assign rose = ext_irq_in[i] && !irq_prev_r[i];
            assign fell = !ext_irq_in[i] && irq_prev_r[i];
            // select pair picks the edge for this input
            always_comb
            begin
                mode = port9_pkg::edge_mode_t'({fall_r[i], rise_r[i]});
                unique case (mode)
                    port9_pkg::EDGE_NONE: event_nxt[i] = 1'b0;
                    port9_pkg::EDGE_RISE: event_nxt[i] = rose;
                    port9_pkg::EDGE_FALL: event_nxt[i] = fell;
                    port9_pkg::EDGE_BOTH: event_nxt[i] = rose || fell;
                endcase
            end

            // a selected rising edge pulses one cycle later
            chk_rise_event: assert property (
                (func_r[i] && rise_r[i] && rose) |=> event_r[i])
                else $error("selected rising edge gave no event");
            // no event while the pin is an address output
            chk_irq_gated: assert property (
                event_r[i] |-> $past(func_r[i] && (fall_r[i] || rise_r[i])))
                else $error("event without interrupt function or select");
            // events are single-cycle pulses; a new edge may follow
            chk_event_pulse: assert property (
                (event_r[i] && $stable(ext_irq_in[i])) |=> !event_r[i])
                else $error("edge event lasted more than one cycle");
        end
    endgenerate

    // interrupt function gates the events; otherwise address output
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            event_r <= 3'h0;
            a_out_r <= 3'h0;
            a_oe_r  <= 3'h0;
        end
        else
        begin
            event_r <= event_nxt & func_r;
            a_out_r <= addr_hi_src;
            a_oe_r  <= ~func_r;
        end
    end
    assign ext_irq_event = event_r;
    assign addr_hi_pins  = '{out: a_out_r, oe: a_oe_r};

    chk_pu_impl_mask: assert property (
        (pu_r & ~PU_IMPL) == 16'h0)
        else $error("unimplemented pull-up bit set");

    chk_pu_word_write: assert property (
        (wr_go && hit(aw_addr_r, `IDX_PU_WORD) && w_strb_r[1:0] == 2'h3)
        |=> pullup_en == ($past(w_data_r[15:0]) & PU_IMPL))
        else $error("pull-up word write not applied");

    chk_pu_high_alias: assert property (
        (wr_go && hit(aw_addr_r, `IDX_PU_HIGH) && w_strb_r[0])
        |=> pullup_en[15:8] == ($past(w_data_r[7:0]) & PU_IMPL[15:8])
            && $stable(pullup_en[7:0]))
        else $error("high byte write did not reach bits 15 to 8");

    chk_fall_read: assert property (
        (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `IDX_FALL_SEL))
        |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(fall_r), 5'h0})
        else $error("falling select read wrong");

    chk_rise_read: assert property (
        (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `IDX_RISE_SEL))
        |=> s_axi_rvalid && s_axi_rdata[4:0] == 5'h0
            && s_axi_rdata[7:5] == $past(rise_r))
        else $error("rising select read wrong");

    chk_spd_read: assert property (
        (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `IDX_SPD_DATA))
        |=> s_axi_rdata[31:4] == 28'h0
            && (s_axi_rdata[3:0] & ~$past(spd_oe_r))
            == ($past(spd_in) & ~$past(spd_oe_r) & {4{LARGE_VARIANT}}))
        else $error("input-mode read is not the pin level");

    chk_spd_drive: assert property (
        (LARGE_VARIANT && wr_go && w_strb_r[0]
         && hit(aw_addr_r, `IDX_SPD_DATA))
        |=> spd_pins.out == $past(w_data_r[3:0]))
        else $error("simple port write not driven at once");

    chk_bresp_after: assert property (
        wr_go |=> s_axi_bvalid
            && (s_axi_bresp == `RESP_SLVERR) == !mapped($past(aw_addr_r)))
        else $error("write response missing or wrong");

endmodule

// *** port_pullup_edge_and_simple_port_tb.sv ***
// register-level bench of the port block against a board model
`include "port9_defs.svh"
module port_pullup_edge_and_simple_port_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  mclk = 0;
    logic                  resetn = 0;
    logic [31:0]           s_axi_awaddr = 0, s_axi_wdata = 0;
    logic [31:0]           s_axi_araddr = 0, s_axi_rdata;
    logic [3:0]            s_axi_wstrb = 0;
    logic                  s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic                  s_axi_bready = 0, s_axi_arvalid = 0;
    logic                  s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic [15:0]           pullup_en;
    logic [2:0]            ext_irq_in, ext_irq_event;
    logic [2:0]            irq_level = 0, addr_hi_src = 3'h5;
    logic [3:0]            spd_in, board_level = 4'h8;
    port9_pkg::addr_drive_t addr_hi_pins;
    port9_pkg::spd_drive_t  spd_pins;
    logic [15:0]           pu_small;
    port9_pkg::spd_drive_t  spd_small;
    int                    n_errors = 0, n_checks = 0;
    int                    ev_cnt[3] = '{0, 0, 0}, base[3];

    port9_regs #(.LARGE_VARIANT(1'b1)) uut (.mclk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pullup_en, .ext_irq_in, .ext_irq_event, .addr_hi_src,
        .addr_hi_pins, .spd_in, .spd_pins);

    // small package copy shares the bus; its responses are left open, only its pull-ups and pins are checked
    port9_regs #(.LARGE_VARIANT(1'b0)) uut_small (.mclk, .resetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready, .pullup_en(pu_small), .ext_irq_in,
        .ext_irq_event(), .addr_hi_src, .addr_hi_pins(), .spd_in,
        .spd_pins(spd_small));

    pin_board_model board (.spd_pins, .board_level, .irq_level, .spd_in,
        .ext_irq_in);

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        for (int k = 0; k < 3; k++)
            if (ext_irq_event[k] === 1'b1)
                ev_cnt[k]++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] idx, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        bit ta;
        bit tw;
        ta = 0;
        tw = 0;
        @(posedge mclk);
        s_axi_awaddr <= idx << 2;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw))
        begin
            @(negedge mclk);
            ta |= s_axi_awvalid && s_axi_awready === 1'b1;
            tw |= s_axi_wvalid && s_axi_wready === 1'b1;
            @(posedge mclk);
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        do
        begin
            @(negedge mclk);
        end
        while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, er);
        @(posedge mclk);
        s_axi_bready <= 1'b0;
        // address pins follow the function bits one edge later
        @(negedge mclk);
    endtask

    task automatic rd(input logic [31:0] idx, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= idx << 2;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge mclk);
        end
        while (s_axi_arready !== 1'b1);
        @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(negedge mclk);
        end
        while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, e);
        check(s_axi_rresp, er);
        @(posedge mclk);
        s_axi_rready <= 1'b0;
    endtask

    // fixed waits cover the two-edge event latency with margin
    task automatic pulse_check(input logic [2:0] lvl, input logic [2:0] e);
        @(posedge mclk);
        base = ev_cnt;
        irq_level <= lvl;
        repeat (6) @(posedge mclk);
        for (int k = 0; k < 3; k++)
            check(ev_cnt[k] - base[k], e[k]);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(`IDX_PU_WORD, 32'h0, `RESP_OKAY);
        check(pullup_en, 16'h0);
        wr(`IDX_PU_WORD, 32'hFFFF, 4'h3, `RESP_OKAY);
        check(pullup_en, `PU_FULL_MASK);
        check(pu_small, `PU_SMALL_MASK);
        wr(`IDX_PU_HIGH, 32'h5A, 4'h1, `RESP_OKAY);
        wr(`IDX_PU_WORD, 32'h1234, 4'h1, `RESP_OKAY);
        rd(`IDX_PU_WORD, 32'h5A34, `RESP_OKAY);
        rd(`IDX_PU_HIGH, 32'h5A, `RESP_OKAY);
        check(pullup_en, 16'h5A34);
        check(pu_small, 16'h5A34 & `PU_SMALL_MASK);
        $display("test pull-up done");
        rd(`IDX_FALL_SEL, 32'h0, `RESP_OKAY);
        rd(`IDX_RISE_SEL, 32'h0, `RESP_OKAY);
        wr(`IDX_FALL_SEL, 32'hFF, 4'h1, `RESP_OKAY);
        rd(`IDX_FALL_SEL, 32'hE0, `RESP_OKAY);
        wr(`IDX_RISE_SEL, 32'hFF, 4'h1, `RESP_OKAY);
        rd(`IDX_RISE_SEL, 32'hE0, `RESP_OKAY);
        wr(32'h100, 32'hFF, 4'hF, `RESP_SLVERR);
        rd(32'h100, 32'h0, `RESP_SLVERR);
        $display("test selects done");
        check(addr_hi_pins.oe, 3'h7);
        check(addr_hi_pins.out, addr_hi_src);
        wr(`IDX_FUNC_CTL, 32'hE000, 4'h2, `RESP_OKAY);
        check(addr_hi_pins.oe, 3'h0);
        for (int m = 0; m < 4; m++)
        begin
            wr(`IDX_FALL_SEL, {24'h0, {3{m[1]}}, 5'h0}, 4'h1, `RESP_OKAY);
            wr(`IDX_RISE_SEL, {24'h0, {3{m[0]}}, 5'h0}, 4'h1, `RESP_OKAY);
            pulse_check(3'h7, {3{m[0]}});
            pulse_check(3'h0, {3{m[1]}});
        end
        pulse_check(3'h4, 3'h4);
        pulse_check(3'h0, 3'h4);
        wr(`IDX_FALL_SEL, 32'h0, 4'h1, `RESP_OKAY);
        wr(`IDX_RISE_SEL, 32'h0, 4'h1, `RESP_OKAY);
        wr(`IDX_FUNC_CTL, 32'h0, 4'h2, `RESP_OKAY);
        check(addr_hi_pins.oe, 3'h7);
        $display("test edges done");
        rd(`IDX_SPD_DIR, 32'hF, `RESP_OKAY);
        check(spd_pins.oe, 4'h0);
        wr(`IDX_SPD_DIR, 32'h0, 4'h1, `RESP_OKAY);
        wr(`IDX_SPD_DATA, 32'hA5, 4'h1, `RESP_OKAY);
        rd(`IDX_SPD_DATA, 32'h5, `RESP_OKAY);
        check(spd_pins, 8'h5F);
        wr(`IDX_SPD_DIR, 32'hC, 4'h1, `RESP_OKAY);
        rd(`IDX_SPD_DIR, 32'hC, `RESP_OKAY);
        rd(`IDX_SPD_DATA, 32'h9, `RESP_OKAY);
        wr(`IDX_SPD_DATA, 32'hF, 4'h1, `RESP_OKAY);
        rd(`IDX_SPD_DATA, 32'hB, `RESP_OKAY);
        check(spd_pins.oe, 4'h3);
        wr(`IDX_SPD_DIR, 32'h0, 4'h1, `RESP_OKAY);
        rd(`IDX_SPD_DATA, 32'hF, `RESP_OKAY);
        check(spd_small, 8'h00);
        $display("test simple port done");
        tally_and_finish;
    end
endmodule
